//--- verilog/asr_pkg.sv
// Notes on behaviour
// - Oversample line at sixteen; shift once per bit.
// - Baud rate from divisor; high-speed select divides less.
// - Asynchronous only with sync clear, port enabled.
// - Nine-bit characters when ninth-bit enable set.
// - Accept characters only while continuous receive set.
// - Flag on completion; request needs receive enable.
// - Status shows ninth bit, framing, overrun.
// - Data register read returns low eight bits.
// - Clearing continuous receive clears latched errors.
// - Forward only with global and peripheral enables.
// - Address filter applies when address detect and ninth-bit enable set.
// - Detect cleared: every character loads and flags, unless the flag is still pending (overrun).
// - Priority bit routes request high or low.
package asr_pkg;
    localparam int ADDR_W = 8;

    // Byte offsets of the register words.
    localparam logic [7:0] OFS_INT_CONTROL = 8'h00;
    localparam logic [7:0] OFS_PERIPH_FLAGS1 = 8'h04;
    localparam logic [7:0] OFS_PERIPH_EN1 = 8'h08;
    localparam logic [7:0] OFS_PERIPH_PRIO1 = 8'h0C;
    localparam logic [7:0] OFS_RX_STATUS = 8'h10;
    localparam logic [7:0] OFS_RX_DATA = 8'h14;
    localparam logic [7:0] OFS_TX_DATA = 8'h18;
    localparam logic [7:0] OFS_TX_STATUS = 8'h1C;
    localparam logic [7:0] OFS_BAUD_DIV = 8'h20;

    // Field positions.
    localparam int GLOBAL_IE_BIT = 7;
    localparam int PERIPH_IE_BIT = 6;
    localparam int RX_FLAG_BIT = 5;
    localparam int RX_IE_BIT = 5;
    localparam int RX_PRIO_BIT = 5;
    localparam int PORT_EN_BIT = 7;
    localparam int NINTH_EN_BIT = 6;
    localparam int CONT_RX_BIT = 4;
    localparam int ADDR_DET_BIT = 3;
    localparam int FRAME_ERR_BIT = 2;
    localparam int OVERRUN_BIT = 1;
    localparam int NINTH_DATA_BIT = 0;
    localparam int SYNC_MODE_BIT = 4;
    localparam int HI_SPEED_BIT = 2;
    localparam int SHIFT_EMPTY_BIT = 1;

    // Writable bits and values after reset.
    localparam logic [7:0] INT_CTL_WR_MASK = 8'hC0;
    localparam logic [7:0] RX_CTL_WR_MASK = 8'hF8;
    localparam logic [7:0] TX_CTL_WR_MASK = 8'hF5;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] TX_STATUS_RST = 8'h02;
    localparam logic LINE_IDLE = 1'b1;

    // Oversampling points and character lengths, in ticks and bits.
    localparam logic [3:0] SUB_LAST = 4'hF;
    localparam logic [3:0] SAMPLE_A = 4'h7;
    localparam logic [3:0] SAMPLE_B = 4'h8;
    localparam logic [3:0] SAMPLE_C = 4'h9;
    localparam logic [3:0] BITS8_LAST = 4'h7;
    localparam logic [3:0] BITS9_LAST = 4'h8;
    localparam logic [1:0] LOW_SPEED_PRE_LAST = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asr_rx_state_e;
    typedef enum logic [3:0] {
        RG_INT_CTL, RG_PFLAG1, RG_PEN1, RG_PPRI1, RG_RX_STAT,
        RG_RX_DATA, RG_TX_DATA, RG_TX_STAT, RG_BAUD, RG_NONE
    } asr_reg_e;
endpackage

//--- verilog/asr_sync.sv
// Two-stage synchroniser for the asynchronous receive pin.
module asr_sync
    import asr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } asr_sync_s;

    asr_sync_s st, n;

    // Only the second stage is ever read downstream.
    always_comb begin
        n = st;
        n.s1 = din;
        n.s2 = st.s1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= {LINE_IDLE, LINE_IDLE};
        end else if (ce) begin
            st <= n;
        end
    end

    assign dout = st.s2;
endmodule

//--- verilog/asr_baud.sv
// Sixteen-times oversampling tick generator driven by the baud divisor.
module asr_baud
    import asr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic enable,
    input wire logic [7:0] divisor,
    input wire logic high_speed,
    output logic tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic [1:0] pre;
        logic tick;
    } asr_baud_s;

    asr_baud_s st, n;

    // One tick every divisor+1 clocks, or four times that at low speed.
    always_comb begin
        n = st;
        n.tick = 1'b0;
        if (!enable) begin
            n.cnt = divisor;
            n.pre = 2'h0;
        end else if (st.cnt == 8'h00) begin
            n.cnt = divisor;
            if (high_speed || st.pre == LOW_SPEED_PRE_LAST) begin
                n.pre = 2'h0;
                n.tick = 1'b1;
            end else begin
                n.pre = st.pre + 2'h1;
            end
        end else begin
            n.cnt = st.cnt - 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else if (ce) begin
            st <= n;
        end
    end

    assign tick = st.tick;
endmodule

//--- verilog/asr_top.sv
// Asynchronous serial receiver with an AXI4-Lite register slave.
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
module asr_top
    import asr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic rx_pin,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq_high,
    output logic irq_low
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic aw_got;
        asr_reg_e aw_idx;
        logic w_got;
        logic [7:0] wbyte;
        logic wlane0;
        logic [7:0] int_ctl;
        logic [7:0] pen1;
        logic [7:0] ppri1;
        logic [7:0] rx_ctl;
        logic [7:0] tx_ctl;
        logic [7:0] tx_data;
        logic [7:0] baud;
        logic rx_flag;
        logic frame_err;
        logic overrun;
        logic ninth;
        logic [7:0] rx_data;
        asr_rx_state_e state;
        logic [3:0] sub;
        logic [3:0] bitcnt;
        logic [2:0] votes;
        logic [8:0] shift;
        logic irq_high;
        logic irq_low;
    } asr_top_s;

    asr_top_s st, n;
    logic rx_s;
    logic tick;
    logic rx_en;
    logic rd_rx;
    logic done;
    logic filtered;
    logic stop_bit;

    // Word-aligned address to register index; anything else is unmapped.
    function automatic asr_reg_e reg_dec(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_INT_CONTROL: reg_dec = RG_INT_CTL;
            OFS_PERIPH_FLAGS1: reg_dec = RG_PFLAG1;
            OFS_PERIPH_EN1: reg_dec = RG_PEN1;
            OFS_PERIPH_PRIO1: reg_dec = RG_PPRI1;
            OFS_RX_STATUS: reg_dec = RG_RX_STAT;
            OFS_RX_DATA: reg_dec = RG_RX_DATA;
            OFS_TX_DATA: reg_dec = RG_TX_DATA;
            OFS_TX_STATUS: reg_dec = RG_TX_STAT;
            OFS_BAUD_DIV: reg_dec = RG_BAUD;
            default: reg_dec = RG_NONE;
        endcase
    endfunction

    // Majority of three mid-bit samples rejects single-tick glitches.
    function automatic logic maj3(input logic [2:0] v);
        maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    asr_sync asr_sync_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .din(rx_pin),
        .dout(rx_s)
    );

    // The divider only runs while the port is in asynchronous receive.
    asr_baud asr_baud_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .enable(rx_en),
        .divisor(st.baud),
        .high_speed(st.tx_ctl[HI_SPEED_BIT]),
        .tick(tick)
    );

    // A pending overrun halts reception until software drops continuous receive.
    assign rx_en = st.rx_ctl[PORT_EN_BIT] & ~st.tx_ctl[SYNC_MODE_BIT] & st.rx_ctl[CONT_RX_BIT]
                   & ~st.overrun;

    always_comb begin
        asr_reg_e ridx;
        logic [7:0] rbyte;
        n = st;
        ridx = RG_NONE;
        rbyte = 8'h00;
        rd_rx = 1'b0;
        done = 1'b0;
        filtered = 1'b0;
        stop_bit = 1'b1;

        // Write address and data are taken independently, in either order.
        if (st.awready && awvalid) begin
            n.aw_got = 1'b1;
            n.aw_idx = reg_dec(awaddr);
        end
        if (st.wready && wvalid) begin
            n.w_got = 1'b1;
            n.wbyte = wdata[7:0];
            n.wlane0 = wstrb[0];
        end
        if (st.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (n.aw_got && n.w_got && !n.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = (n.aw_idx == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (n.wlane0) begin
                case (n.aw_idx)
                    RG_INT_CTL: n.int_ctl = n.wbyte & INT_CTL_WR_MASK;
                    RG_PEN1: n.pen1 = n.wbyte;
                    RG_PPRI1: n.ppri1 = n.wbyte;
                    RG_RX_STAT: n.rx_ctl = n.wbyte & RX_CTL_WR_MASK;
                    RG_TX_DATA: n.tx_data = n.wbyte;
                    RG_TX_STAT: n.tx_ctl = n.wbyte & TX_CTL_WR_MASK;
                    RG_BAUD: n.baud = n.wbyte;
                    default: ;
                endcase
            end
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;

        // Read channel; the data register read frees the receive buffer.
        if (st.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (st.arready && arvalid) begin
            ridx = reg_dec(araddr);
            case (ridx)
                RG_INT_CTL: rbyte = st.int_ctl;
                RG_PFLAG1: rbyte[RX_FLAG_BIT] = st.rx_flag;
                RG_PEN1: rbyte = st.pen1;
                RG_PPRI1: rbyte = st.ppri1;
                RG_RX_STAT: begin
                    rbyte = st.rx_ctl;
                    rbyte[FRAME_ERR_BIT] = st.frame_err;
                    rbyte[OVERRUN_BIT] = st.overrun;
                    rbyte[NINTH_DATA_BIT] = st.ninth;
                end
                RG_RX_DATA: rbyte = st.rx_data;
                RG_TX_STAT: begin
                    rbyte = st.tx_ctl;
                    rbyte[SHIFT_EMPTY_BIT] = 1'b1;
                end
                default: rbyte = 8'h00;
            endcase
            n.rvalid = 1'b1;
            n.rdata = {24'h00_0000, rbyte};
            n.rresp = (ridx == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
            rd_rx = (ridx == RG_RX_DATA);
        end
        n.arready = !n.rvalid;
        if (rd_rx) begin
            n.rx_flag = 1'b0;
        end

        // Receive state machine, advanced by the sixteen-times tick.
        if (!rx_en) begin
            n.state = RX_IDLE;
            n.sub = 4'h0;
        end else if (tick) begin
            n.sub = st.sub + 4'h1;
            if (st.sub == SAMPLE_A || st.sub == SAMPLE_B || st.sub == SAMPLE_C) begin
                n.votes = {st.votes[1:0], rx_s};
            end
            case (st.state)
                RX_IDLE: begin
                    n.sub = 4'h0;
                    if (!rx_s) begin
                        n.state = RX_START;
                    end
                end
                RX_START: begin
                    if (st.sub == SUB_LAST) begin
                        if (maj3(st.votes)) begin
                            n.state = RX_IDLE;
                        end else begin
                            n.state = RX_DATA;
                            n.bitcnt = 4'h0;
                        end
                    end
                end
                RX_DATA: begin
                    if (st.sub == SUB_LAST) begin
                        n.shift = {maj3(st.votes), st.shift[8:1]};
                        n.bitcnt = st.bitcnt + 4'h1;
                        if (st.bitcnt == (st.rx_ctl[NINTH_EN_BIT] ? BITS9_LAST : BITS8_LAST)) begin
                            n.state = RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    // Finishing at mid stop bit leaves room to catch the next start edge.
                    if (st.sub == SAMPLE_C) begin
                        stop_bit = maj3(n.votes);
                        done = 1'b1;
                        n.state = RX_IDLE;
                        n.sub = 4'h0;
                    end
                end
                default: n.state = RX_IDLE;
            endcase
        end

        // Character completion: filter, overrun check, then load the buffer.
        if (done) begin
            filtered = st.rx_ctl[ADDR_DET_BIT] && st.rx_ctl[NINTH_EN_BIT] && !st.shift[8];
            if (filtered) begin
                n.rx_flag = n.rx_flag;
            end else if (st.rx_flag && !rd_rx) begin
                n.overrun = 1'b1;
            end else begin
                n.rx_data = st.rx_ctl[NINTH_EN_BIT] ? st.shift[7:0] : st.shift[8:1];
                n.ninth = st.rx_ctl[NINTH_EN_BIT] & st.shift[8];
                n.frame_err = ~stop_bit;
                n.rx_flag = 1'b1;
            end
        end

        // Dropping continuous receive clears latched errors at once.
        if (!n.rx_ctl[CONT_RX_BIT]) begin
            n.frame_err = 1'b0;
            n.overrun = 1'b0;
        end

        // Request needs flag, enable, both global gates; priority picks the line.
        n.irq_high = n.int_ctl[GLOBAL_IE_BIT] & n.int_ctl[PERIPH_IE_BIT] & n.rx_flag
                     & n.pen1[RX_IE_BIT] & n.ppri1[RX_PRIO_BIT];
        n.irq_low = n.int_ctl[GLOBAL_IE_BIT] & n.int_ctl[PERIPH_IE_BIT] & n.rx_flag
                    & n.pen1[RX_IE_BIT] & ~n.ppri1[RX_PRIO_BIT];
    end

    // Reset puts the bus channels ready and every register at its reset value.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.tx_ctl <= TX_STATUS_RST;
            st.aw_idx <= RG_NONE;
        end else if (ce) begin
            st <= n;
        end
    end

    assign awready = st.awready;
    assign wready = st.wready;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign arready = st.arready;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;
    assign irq_high = st.irq_high;
    assign irq_low = st.irq_low;

    // Checks on the receiver and its register view.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    sequence rx_read_s;
        st.arready && arvalid && reg_dec(araddr) == RG_RX_DATA && !done;
    endsequence

    sequence stat_read_s;
        st.arready && arvalid && reg_dec(araddr) == RG_RX_STAT;
    endsequence

    property rx_read_p;
        rx_read_s |=> !st.rx_flag && st.rvalid && st.rdata[7:0] == $past(st.rx_data);
    endproperty

    irq_gate_a: assert property ((irq_high || irq_low) |->
        st.int_ctl[GLOBAL_IE_BIT] && st.int_ctl[PERIPH_IE_BIT] && st.rx_flag && st.pen1[RX_IE_BIT])
        else $error("interrupt without all enables");
    irq_prio_a: assert property ((irq_high |-> st.ppri1[RX_PRIO_BIT]) and
        (irq_low |-> !st.ppri1[RX_PRIO_BIT]))
        else $error("interrupt on wrong priority line");
    rx_disabled_a: assert property (!rx_en |=> st.state == RX_IDLE)
        else $error("receiver active while disabled");
    err_clear_a: assert property ($fell(st.rx_ctl[CONT_RX_BIT]) |-> !st.frame_err && !st.overrun)
        else $error("errors kept after receive disable");
    addr_filter_a: assert property ($rose(st.rx_flag) && st.rx_ctl[ADDR_DET_BIT]
        && st.rx_ctl[NINTH_EN_BIT] |-> st.ninth)
        else $error("non-address character loaded");
    flag_cause_a: assert property ($rose(st.rx_flag) |-> $past(st.state) == RX_STOP)
        else $error("receive flag set outside completion");
    eight_bit_a: assert property ($rose(st.rx_flag) && !st.rx_ctl[NINTH_EN_BIT] |-> !st.ninth)
        else $error("ninth bit set in eight-bit mode");
    overrun_set_a: assert property (done && !filtered && st.rx_flag && !rd_rx
        |=> st.overrun || !st.rx_ctl[CONT_RX_BIT])
        else $error("overrun not flagged");
    bit_step_a: assert property (st.state == RX_DATA && $changed(st.bitcnt)
        |-> $past(tick) && $past(st.sub) == SUB_LAST)
        else $error("bit shifted off the bit boundary");
    rx_read_a: assert property (rx_read_p)
        else $error("data read did not return buffer or free it");
    stat_read_a: assert property (stat_read_s |=> st.rdata[OVERRUN_BIT] == $past(st.overrun))
        else $error("status read lost overrun bit");
    bresp_hold_a: assert property (st.bvalid && !bready |=> st.bvalid && $stable(st.bresp))
        else $error("write response dropped early");
endmodule

//--- sim/asr_node.sv
// Remote serial node that drives the receive line with whole frames, LSB first.
module asr_node
    import asr_pkg::*;
(
    input wire logic aclk,
    output logic line
);
    timeunit 1ns;
    timeprecision 1ps;

    // The line rests at the idle level, so a stray start bit is never seen between frames.
    initial begin
        line = LINE_IDLE;
    end

    // Sends start, data bits LSB first, then the given stop level; each bit lasts bit_clks clocks.
    task automatic send(input logic [8:0] data, input int nbits, input logic stop, input int bit_clks);
        logic [10:0] frame;
        frame = 11'h7FF;
        frame[0] = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            frame[i + 1] = data[i];
        end
        frame[nbits + 1] = stop;
        @(posedge aclk);
        for (int i = 0; i < nbits + 2; i++) begin
            line <= frame[i];
            repeat (bit_clks) @(posedge aclk);
        end
        line <= LINE_IDLE;
        repeat (bit_clks) @(posedge aclk);
    endtask
endmodule

//--- sim/asr_top_tb.sv
// Self-checking bench for the serial receiver and its register slave.
module asr_top_tb
    import asr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int FAST_BIT = 16;
    logic aclk, aresetn, ce, rx_pin, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq_high, irq_low;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] data;
    int num_errors = 0;
    int comparisons = 0;

    asr_top asr_top_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce), .rx_pin(rx_pin), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .irq_high(irq_high), .irq_low(irq_low));
    asr_node asr_node_inst (.aclk(aclk), .line(rx_pin));

    // Free-running 200 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // Prints the counts and the verdict, then stops the run.
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    // A hung handshake counts as a mismatch and ends the run at once.
    task automatic guard(inout int n, input string what);
        n++;
        if (n > 60) begin
            num_errors++;
            $display("Error %s expected handshake seen timeout", what);
            conclude();
        end
    endtask

    // Offers address and data together; each is released at the edge where it is taken.
    task automatic axi_write(input logic [7:0] addr, input logic [31:0] d, output logic [1:0] r);
        bit aw_done;
        bit w_done;
        int n;
        aw_done = 0;
        w_done = 0;
        n = 0;
        awaddr <= addr;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1;
                wvalid <= 1'b0;
            end
            guard(n, "write request");
        end
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            guard(n, "write response");
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] addr, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        araddr <= addr;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            guard(n, "read address");
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            guard(n, "read data");
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wreg(input logic [7:0] addr, input logic [7:0] d);
        axi_write(addr, {24'h0000_00, d}, resp);
    endtask

    task automatic expect_reg(input logic [7:0] addr, input logic [31:0] exp, input string what);
        axi_read(addr, data, resp);
        check_word(what, exp, data);
    endtask

    // Polls the flag register under a bound; the flag lands a few clocks after the middle of the stop bit.
    task automatic wait_rx();
        int n;
        n = 0;
        do begin
            axi_read(OFS_PERIPH_FLAGS1, data, resp);
            guard(n, "receive flag");
        end while (data[RX_FLAG_BIT] !== 1'b1);
    endtask

    task automatic sc_reset_map();
        logic [7:0] ofs [9] = '{OFS_INT_CONTROL, OFS_PERIPH_FLAGS1, OFS_PERIPH_EN1, OFS_PERIPH_PRIO1,
            OFS_RX_STATUS, OFS_RX_DATA, OFS_TX_DATA, OFS_TX_STATUS, OFS_BAUD_DIV};
        foreach (ofs[i]) begin
            expect_reg(ofs[i], (ofs[i] == OFS_TX_STATUS) ? 32'h0000_0002 : 32'h0000_0000, "reset value");
        end
        axi_write(8'h24, 32'h0000_00FF, resp);
        check_word("unmapped write resp", {30'h0000_0000, RESP_SLVERR}, {30'h0000_0000, resp});
        axi_read(8'h24, data, resp);
        check_word("unmapped read resp", {30'h0000_0000, RESP_SLVERR}, {30'h0000_0000, resp});
        check_word("unmapped read data", 32'h0000_0000, data);
        wreg(OFS_PERIPH_FLAGS1, 8'hFF);
        expect_reg(OFS_PERIPH_FLAGS1, 32'h0000_0000, "read-only flags");
        wreg(OFS_TX_STATUS, 8'hFF);
        expect_reg(OFS_TX_STATUS, 32'h0000_00F7, "tx status mask");
    endtask

    // Fast baud, 8-bit character; the request follows enables, gating and priority.
    task automatic sc_basic_irq();
        wreg(OFS_BAUD_DIV, 8'h00);
        wreg(OFS_TX_STATUS, 8'h04);
        wreg(OFS_INT_CONTROL, 8'hC0);
        wreg(OFS_PERIPH_EN1, 8'h20);
        wreg(OFS_PERIPH_PRIO1, 8'h20);
        wreg(OFS_RX_STATUS, 8'h90);
        asr_node_inst.send(9'h0A5, 8, 1'b1, FAST_BIT);
        wait_rx();
        check_bit("irq high", 1'b1, irq_high);
        check_bit("irq low", 1'b0, irq_low);
        wreg(OFS_PERIPH_PRIO1, 8'h00);
        check_bit("irq low after prio", 1'b1, irq_low);
        check_bit("irq high after prio", 1'b0, irq_high);
        wreg(OFS_INT_CONTROL, 8'h40);
        check_bit("irq without global", 1'b0, irq_low);
        wreg(OFS_INT_CONTROL, 8'h80);
        check_bit("irq without periph", 1'b0, irq_low);
        wreg(OFS_INT_CONTROL, 8'hC0);
        wreg(OFS_PERIPH_EN1, 8'h00);
        check_bit("irq without rx enable", 1'b0, irq_low);
        wreg(OFS_PERIPH_EN1, 8'h20);
        expect_reg(OFS_RX_STATUS, 32'h0000_0090, "clean status");
        expect_reg(OFS_RX_DATA, 32'h0000_00A5, "rx data");
        expect_reg(OFS_PERIPH_FLAGS1, 32'h0000_0000, "flag after read");
        check_bit("irq after read", 1'b0, irq_low);
    endtask

    task automatic sc_nine_framing();
        wreg(OFS_RX_STATUS, 8'hD0);
        asr_node_inst.send(9'h13C, 9, 1'b0, FAST_BIT);
        wait_rx();
        expect_reg(OFS_RX_STATUS, 32'h0000_00D5, "ninth bit and framing");
        expect_reg(OFS_RX_DATA, 32'h0000_003C, "nine-bit data");
        asr_node_inst.send(9'h0C3, 9, 1'b1, FAST_BIT);
        wait_rx();
        expect_reg(OFS_RX_STATUS, 32'h0000_00D0, "framing rewritten");
        expect_reg(OFS_RX_DATA, 32'h0000_00C3, "second nine-bit data");
    endtask

    task automatic sc_overrun();
        wreg(OFS_RX_STATUS, 8'h90);
        asr_node_inst.send(9'h011, 8, 1'b1, FAST_BIT);
        wait_rx();
        asr_node_inst.send(9'h022, 8, 1'b1, FAST_BIT);
        expect_reg(OFS_RX_STATUS, 32'h0000_0092, "overrun set");
        expect_reg(OFS_RX_DATA, 32'h0000_0011, "first char kept");
        asr_node_inst.send(9'h033, 8, 1'b1, FAST_BIT);
        expect_reg(OFS_PERIPH_FLAGS1, 32'h0000_0000, "halted after overrun");
        wreg(OFS_RX_STATUS, 8'h80);
        expect_reg(OFS_RX_STATUS, 32'h0000_0080, "errors cleared");
        wreg(OFS_RX_STATUS, 8'h90);
        asr_node_inst.send(9'h044, 8, 1'b1, FAST_BIT);
        wait_rx();
        expect_reg(OFS_RX_DATA, 32'h0000_0044, "reception resumed");
    endtask

    task automatic sc_addr_detect();
        wreg(OFS_RX_STATUS, 8'hD8);
        asr_node_inst.send(9'h055, 9, 1'b1, FAST_BIT);
        expect_reg(OFS_PERIPH_FLAGS1, 32'h0000_0000, "data char filtered");
        asr_node_inst.send(9'h1A7, 9, 1'b1, FAST_BIT);
        wait_rx();
        expect_reg(OFS_RX_DATA, 32'h0000_00A7, "address char");
        wreg(OFS_RX_STATUS, 8'hD0);
        asr_node_inst.send(9'h042, 9, 1'b1, FAST_BIT);
        wait_rx();
        check_bit("irq after filter off", 1'b1, irq_low);
        expect_reg(OFS_RX_DATA, 32'h0000_0042, "data after filter off");
    endtask

    // Each gating condition alone must keep a character out.
    task automatic sc_disabled();
        logic [7:0] rxs [3] = '{8'h80, 8'h90, 8'h10};
        logic [7:0] txs [3] = '{8'h04, 8'h14, 8'h04};
        foreach (rxs[i]) begin
            wreg(OFS_TX_STATUS, txs[i]);
            wreg(OFS_RX_STATUS, rxs[i]);
            asr_node_inst.send(9'h05A, 8, 1'b1, FAST_BIT);
            expect_reg(OFS_PERIPH_FLAGS1, 32'h0000_0000, "gated reception");
        end
    endtask

    // Low-speed range with divisor 1: tick every 4*2 clocks, so 128 clocks a bit.
    task automatic sc_slow_baud();
        wreg(OFS_TX_STATUS, 8'h00);
        wreg(OFS_BAUD_DIV, 8'h01);
        wreg(OFS_RX_STATUS, 8'h90);
        asr_node_inst.send(9'h096, 8, 1'b1, 128);
        wait_rx();
        expect_reg(OFS_RX_DATA, 32'h0000_0096, "slow baud data");
    endtask

    // Main sequence: reset for 12 clocks, then every scenario in turn.
    initial begin
        aresetn = 1'b0;
        ce = 1'b1;
        awaddr = '0;
        awvalid = 1'b0;
        wdata = '0;
        wstrb = 4'hF;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = '0;
        arvalid = 1'b0;
        rready = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        sc_reset_map();
        sc_basic_irq();
        sc_nine_framing();
        sc_overrun();
        sc_addr_detect();
        sc_disabled();
        sc_slow_baud();
        conclude();
    end
endmodule
